/* File: design/flm_monitor.sv */
/*
  fault and limit monitor: line voltage window,
  absolute or relative current limits, drifting reference,
  event register, relays, lamps, pulse inhibit, fault buffer,
  on an avalon-mm slave with waitrequest.
  assumes core_clk measurements with a meas_valid strobe;
  lock, mains and overtemp are raw pins.
*/
// Chosen here: the placing of the registers and the Avalon-MM slave port.
// Contract
// (RQ1) limit relay closes when current, voltage or power maximum is exceeded
// (RQ2) limit relay releases once no maximum is exceeded any more
// (RQ3) alarm relay activates on any detected fault
// (RQ4) closed-circuit setting chooses whether alarm relay closes or opens on fault
// (RQ5) each relay has a configurable set of indications that switch it
// (RQ6) each relay can be assigned to selectable event register entries
// (RQ7) any fault lights the fault lamp and switches the fault relay
// (RQ8) faults are recorded in a buffer readable once status line selected
// (RQ9) with pulse shutdown enabled, firing is inhibited together with fault
// (RQ10) phase voltages are checked against min and max line limits
// (RQ11) absolute mode compares rms current with under and over limits
// (RQ12) indication when current below lower or above upper limit
// (RQ13) relative mode captures current after reset or lock as reference
// (RQ14) reset runs automatically after startup, restart and mains loss
// (RQ15) slow drift moves the reference so present current stays at 100%
// (RQ16) fast rise over the reference flags relative overcurrent
// (RQ17) fast fall under the reference flags relative undercurrent
// (RQ18) power lamp green in operation, red while reset active
// (RQ19) limit lamp lights with the limit relay
// (RQ20) pulse-lock lamp lights while controller lock is active
// (RQ21) relative over limit 0 to 100%, under limit 0 to 99%
`timescale 1ns/100ps
module flm_monitor #(
  parameter int RESET_CYCLES = flm_pkg::RESET_HOLD_CYC,
  parameter int DRIFT_N      = flm_pkg::DRIFT_SAMPLES,
  parameter int FBUF_DEPTH   = 8
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               meas_valid,
  input  wire logic [2:0][15:0]   line_volt,
  input  wire logic [15:0]        load_curr,
  input  wire logic               lim_curr_max,
  input  wire logic               lim_volt_max,
  input  wire logic               lim_power_max,
  input  wire logic               controller_lock_pin,
  input  wire logic               mains_ok_pin,
  input  wire logic               overtemp_pin,
  output logic                    alarm_relay,
  output logic                    limit_relay,
  output logic                    spare_relay,
  output logic                    power_lamp_green,
  output logic                    power_lamp_red,
  output logic                    limit_lamp,
  output logic                    fault_lamp,
  output logic                    pulse_lock_lamp,
  output logic                    overtemp_lamp,
  output logic                    pulse_inhibit
);
  import flm_pkg::*;

  localparam int RW  = $clog2(RESET_CYCLES + 1);
  localparam int DW  = $clog2(DRIFT_N);
  localparam int FAW = $clog2(FBUF_DEPTH);

  if (RESET_CYCLES < 1 || DRIFT_N < 2 || (DRIFT_N & (DRIFT_N - 1)) != 0)
  begin : g_bad_param
    $error("flm_monitor: bad RESET_CYCLES or DRIFT_N");
  end

  typedef struct packed {
    logic [2:0]        sync1;
    logic [2:0]        sync2;
    logic              lock_q;
    logic [RW-1:0]     hold_cnt;
    logic              rst_act;
    logic [31:0]       ctrl;
    logic [31:0]       uline;
    logic [31:0]       iabs;
    logic [31:0]       irel;
    logic [31:0]       rmask;
    logic [15:0]       ref_cur;
    logic              ref_ok;
    logic              cap_pend;
    logic [DW-1:0]     drift_cnt;
    logic              volt_f;
    logic              under_f;
    logic              over_f;
    logic              lim_f;
    logic [EV_W-1:0]   prev_flt;
    logic              ack;
    logic [31:0]       rdata;
    logic              alarm;
    logic              limit;
    logic              spare;
    logic              fault;
    logic              inhibit;
  } flm_state_type;

  flm_state_type st, next_st;

  logic [2:0]       volt_bad;
  logic [EV_W-1:0]  ev;
  logic             fb_push;
  logic             fb_pop;
  logic             fb_clr;
  logic [EV_W-1:0]  fb_head;
  logic [FAW:0]     fb_count;
  logic             fb_ovf;

  // byte-enable merge of a register write
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // relay drive from its event mask
  function automatic logic hit(input logic [EV_W-1:0] e,
                               input logic [EV_W-1:0] m);
    return |(e & m);
  endfunction : hit

  // one window check per phase
  for (genvar p = 0; p < 3; p++) begin : g_phase
    flm_window_cmp #(.W(16)) u_win (
      .value        (line_volt[p]),
      .lo           (st.uline[15:0]),
      .hi           (st.uline[31:16]),
      .out_of_range (volt_bad[p])   // RQ10
    );
  end

  // event register
  always_comb begin
    ev           = '0;
    ev[EV_VOLT]  = st.volt_f;
    ev[EV_UNDER] = st.under_f;
    ev[EV_OVER]  = st.over_f;
    ev[EV_LIMIT] = st.lim_f;
    ev[EV_LOCK]  = st.sync2[PIN_LOCK];
    ev[EV_OTEMP] = st.sync2[PIN_OTEMP];
    ev[EV_RESET] = st.rst_act;
  end

  // event push and bus strobes to the fault buffer
  assign fb_push = |(ev & FAULT_MASK & ~st.prev_flt); // RQ8
  assign fb_pop  = avs_read && st.ack && avs_address == REG_FBUF
                   && st.ctrl[CTRL_STAT_SEL];         // RQ8
  assign fb_clr  = avs_write && st.ack && avs_address == REG_FBUF
                   && avs_byteenable[0] && avs_writedata[0];

  flm_fault_buf #(.W(EV_W), .DEPTH(FBUF_DEPTH)) u_fbuf (
    .core_clk  (core_clk),
    .rst       (rst),
    .push      (fb_push),
    .push_data (ev),
    .pop       (fb_pop),
    .clr_ovf   (fb_clr),
    .head      (fb_head),
    .count     (fb_count),
    .overflow  (fb_ovf)
  );

  // next state
  always_comb begin
    logic        req;
    logic        lock_rise;
    logic [24:0] cur100;
    logic [24:0] ref_hi;
    logic [24:0] ref_lo;
    logic        rel_over;
    logic        rel_under;
    logic        act_alarm;
    logic [31:0] wv;
    logic [6:0]  pct;
    req       = avs_read || avs_write;
    lock_rise = st.sync2[PIN_LOCK] && !st.lock_q;
    cur100    = 25'(load_curr) * 25'(PCT_FULL);
    ref_hi    = 25'(st.ref_cur) * (25'(PCT_FULL) + 25'(st.irel[22:16]));
    ref_lo    = 25'(st.ref_cur) * (25'(PCT_FULL) - 25'(st.irel[6:0]));
    rel_over  = st.ref_ok && cur100 > ref_hi;   // RQ16
    rel_under = st.ref_ok && cur100 < ref_lo;   // RQ17
    wv        = '0;
    pct       = '0;
    next_st   = st;

    // pin synchronisers
    next_st.sync1  = {overtemp_pin, mains_ok_pin, controller_lock_pin};
    next_st.sync2  = st.sync1;
    next_st.lock_q = st.sync2[PIN_LOCK];

    // automatic reset hold after startup and mains loss
    if (!st.sync2[PIN_MAINS]) begin
      next_st.rst_act  = 1'b1;                  // RQ14
      next_st.hold_cnt = '0;
    end else if (st.rst_act) begin
      if (st.hold_cnt == RW'(RESET_CYCLES - 1)) begin
        next_st.rst_act = 1'b0;
      end else begin
        next_st.hold_cnt = st.hold_cnt + 1'b1;
      end
    end

    // reference capture after reset or lock
    if (st.rst_act || lock_rise) begin
      next_st.cap_pend  = 1'b1;                 // RQ13
      next_st.ref_ok    = 1'b0;
      next_st.drift_cnt = '0;
    end else if (meas_valid && st.cap_pend) begin
      next_st.ref_cur  = load_curr;             // RQ13
      next_st.ref_ok   = 1'b1;
      next_st.cap_pend = 1'b0;
    end else if (meas_valid && st.ref_ok && !rel_over && !rel_under) begin
      // slow drift: one step toward the present current per DRIFT_N samples
      next_st.drift_cnt = st.drift_cnt + 1'b1;
      if (st.drift_cnt == '1 && load_curr > st.ref_cur) begin
        next_st.ref_cur = st.ref_cur + 1'b1;    // RQ15
      end else if (st.drift_cnt == '1 && load_curr < st.ref_cur) begin
        next_st.ref_cur = st.ref_cur - 1'b1;    // RQ15
      end
    end

    // measurement flags refreshed per sample, limit flag every cycle
    if (meas_valid) begin
      next_st.volt_f = |volt_bad;               // RQ10
      if (st.ctrl[CTRL_REL]) begin
        next_st.under_f = rel_under;            // RQ17
        next_st.over_f  = rel_over;             // RQ16
      end else begin
        next_st.under_f = load_curr < st.iabs[15:0];   // RQ11 RQ12
        next_st.over_f  = load_curr > st.iabs[31:16];  // RQ11 RQ12
      end
    end
    next_st.lim_f    = lim_curr_max || lim_volt_max || lim_power_max; // RQ1 RQ2
    next_st.prev_flt = ev & FAULT_MASK;

    // relays, lamps and pulse inhibit
    act_alarm       = hit(ev, st.rmask[7:0]);                // RQ3 RQ5 RQ6
    next_st.alarm   = st.ctrl[CTRL_CLOSED] ? !act_alarm : act_alarm; // RQ4
    next_st.limit   = hit(ev, st.rmask[15:8]);               // RQ1 RQ2 RQ6
    next_st.spare   = hit(ev, st.rmask[23:16]);              // RQ5 RQ6
    next_st.fault   = |(ev & FAULT_MASK);                    // RQ7
    next_st.inhibit = st.ctrl[CTRL_PULSE_OFF] && |(ev & FAULT_MASK); // RQ9

    // bus: answer one cycle after the request is seen
    next_st.ack = req && !st.ack;
    if (req && !st.ack) begin
      unique case (avs_address)
        REG_CTRL:   next_st.rdata = st.ctrl;
        REG_ULINE:  next_st.rdata = st.uline;
        REG_IABS:   next_st.rdata = st.iabs;
        REG_IREL:   next_st.rdata = st.irel;
        REG_RMASK:  next_st.rdata = st.rmask;
        REG_STATUS: next_st.rdata = {12'h000, 4'(fb_count), 3'h0, st.ref_ok,
                                     st.inhibit, st.spare, st.limit,
                                     st.alarm, ev};
        REG_REF:    next_st.rdata = {16'h0000, st.ref_cur};
        REG_FBUF:   next_st.rdata = st.ctrl[CTRL_STAT_SEL]
                                    ? {22'h0, fb_ovf, fb_count != '0, fb_head}
                                    : 32'h0000_0000;          // RQ8
        default:    next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && st.ack) begin
      wv = be_merge(32'h0, avs_writedata, avs_byteenable);
      unique case (avs_address)
        REG_CTRL:  next_st.ctrl  = be_merge(st.ctrl, {28'h0, wv[3:0]},
                                            avs_byteenable);
        REG_ULINE: next_st.uline = be_merge(st.uline, avs_writedata,
                                            avs_byteenable);
        REG_IABS:  next_st.iabs  = be_merge(st.iabs, avs_writedata,
                                            avs_byteenable);
        REG_IREL: begin
          wv = be_merge(st.irel, avs_writedata, avs_byteenable);
          pct = wv[22:16] > PCT_OVER_MAX ? PCT_OVER_MAX : wv[22:16];
          next_st.irel[22:16] = pct;                          // RQ21
          pct = wv[6:0] > PCT_UNDER_MAX ? PCT_UNDER_MAX : wv[6:0];
          next_st.irel[6:0] = pct;                            // RQ21
        end
        REG_RMASK: next_st.rmask = be_merge(st.rmask, {8'h00, avs_writedata[23:0]},
                                            avs_byteenable);
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st         <= '0;
      st.rst_act <= 1'b1;     // RQ14
      st.ctrl    <= CTRL_RST;
      st.uline   <= ULINE_RST;
      st.iabs    <= IABS_RST;
      st.irel    <= IREL_RST;
      st.rmask   <= RMASK_RST;
      st.cap_pend <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign avs_waitrequest  = (avs_read || avs_write) && !st.ack;
  assign avs_readdata     = st.rdata;
  assign alarm_relay      = st.alarm;
  assign limit_relay      = st.limit;
  assign spare_relay      = st.spare;
  assign power_lamp_green = !st.rst_act;           // RQ18
  assign power_lamp_red   = st.rst_act;            // RQ18
  assign limit_lamp       = st.limit;              // RQ19
  assign fault_lamp       = st.fault;              // RQ7
  assign pulse_lock_lamp  = st.sync2[PIN_LOCK];    // RQ20
  assign overtemp_lamp    = st.sync2[PIN_OTEMP];
  assign pulse_inhibit    = st.inhibit;            // RQ9

endmodule : flm_monitor

/* File: design/flm_pkg.sv */
/*
  monitor constants: registers, fields, reset values, events, timing.
  assumes a 25 MHz clock and a word-addressed bus.
*/
package flm_pkg;

  // timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int RESET_HOLD_MS  = 100;
  localparam int RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int DRIFT_SAMPLES  = 64;

  // register word indices (byte address is four times the index)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ULINE  = 4'h1;
  localparam logic [3:0] REG_IABS   = 4'h2;
  localparam logic [3:0] REG_IREL   = 4'h3;
  localparam logic [3:0] REG_RMASK  = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_REF    = 4'h6;
  localparam logic [3:0] REG_FBUF   = 4'h7;

  // control fields
  localparam int CTRL_REL       = 0;
  localparam int CTRL_CLOSED    = 1;
  localparam int CTRL_PULSE_OFF = 2;
  localparam int CTRL_STAT_SEL  = 3;

  // percent limits
  localparam logic [6:0] PCT_OVER_MAX  = 7'h64;
  localparam logic [6:0] PCT_UNDER_MAX = 7'h63;
  localparam logic [7:0] PCT_FULL      = 8'h64;

  // event register bits
  localparam int EV_W     = 8;
  localparam int EV_VOLT  = 0;
  localparam int EV_UNDER = 1;
  localparam int EV_OVER  = 2;
  localparam int EV_LIMIT = 3;
  localparam int EV_LOCK  = 4;
  localparam int EV_OTEMP = 5;
  localparam int EV_RESET = 6;
  localparam logic [7:0] FAULT_MASK = 8'h27;

  // synchroniser slots
  localparam int PIN_LOCK  = 0;
  localparam int PIN_MAINS = 1;
  localparam int PIN_OTEMP = 2;

  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ULINE_RST = 32'h0114_00b8;
  localparam logic [31:0] IABS_RST  = 32'hffff_0000;
  localparam logic [31:0] IREL_RST  = 32'h0014_0014;
  localparam logic [31:0] RMASK_RST = 32'h0000_0867;

endpackage : flm_pkg

/* File: design/flm_window_cmp.sv */
/*
  window comparator: flags a value outside [lo, hi].
  assumes unsigned bounds.
*/
`timescale 1ns/100ps
module flm_window_cmp #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] lo,
  input  wire logic [W-1:0] hi,
  output logic              out_of_range
);
  import flm_pkg::*;

  if (W < 2) begin : g_bad_w
    $error("flm_window_cmp: W too small");
  end

  // below the minimum or above the maximum
  assign out_of_range = (value < lo) || (value > hi);

endmodule : flm_window_cmp

/* File: design/flm_fault_buf.sv */
/*
  fault buffer: fifo of event snapshots, oldest at the head.
  assumes one clock; when full with no pop in that cycle, new entries set sticky overflow.
*/
`timescale 1ns/100ps
module flm_fault_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  input  wire logic         clr_ovf,
  output logic [W-1:0]      head,
  output logic [AW:0]       count,
  output logic              overflow
);
  import flm_pkg::*;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("flm_fault_buf: DEPTH must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ovf;
  } flm_fbuf_type;

  flm_fbuf_type st, next_st;

  // push, pop and overflow bookkeeping
  always_comb begin
    logic do_push;
    logic do_pop;
    do_pop  = pop && (st.cnt != '0);
    do_push = push && (st.cnt != (AW+1)'(DEPTH) || do_pop);
    next_st = st;
    if (do_push) begin
      next_st.mem[st.wp] = push_data;
      next_st.wp         = st.wp + 1'b1;
    end
    if (do_pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    // a push dropped by a full buffer wins over a clear in the same cycle
    if (push && !do_push) begin
      next_st.ovf = 1'b1;
    end else if (clr_ovf) begin
      next_st.ovf = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head     = st.mem[st.rp];
  assign count    = st.cnt;
  assign overflow = st.ovf;

endmodule : flm_fault_buf

/* File: test/flm_monitor_assertions.sv */
/*
  port checker bound to flm_monitor.
  assumes reset line window and relay masks.
*/
`timescale 1ns/100ps
module flm_monitor_checker (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest,
  input wire logic             meas_valid,
  input wire logic [2:0][15:0] line_volt,
  input wire logic             lim_curr_max,
  input wire logic             lim_volt_max,
  input wire logic             lim_power_max,
  input wire logic             controller_lock_pin,
  input wire logic             overtemp_pin,
  input wire logic             limit_relay,
  input wire logic             spare_relay,
  input wire logic             power_lamp_green,
  input wire logic             power_lamp_red,
  input wire logic             limit_lamp,
  input wire logic             fault_lamp,
  input wire logic             pulse_lock_lamp,
  input wire logic             overtemp_lamp,
  input wire logic             pulse_inhibit
);
  import flm_pkg::*;
  logic lim_any;
  logic volt_bad;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // any maximum flag, any phase outside the default window
  assign lim_any  = lim_curr_max | lim_volt_max | lim_power_max;
  assign volt_bad = (line_volt[0] > ULINE_RST[31:16]) | (line_volt[0] < ULINE_RST[15:0])
                  | (line_volt[1] > ULINE_RST[31:16]) | (line_volt[1] < ULINE_RST[15:0])
                  | (line_volt[2] > ULINE_RST[31:16]) | (line_volt[2] < ULINE_RST[15:0]);
  AST_LIMIT_SET: assert property (meas_valid && lim_any |-> ##2 limit_relay)
    else $error("limit set");
  AST_LIMIT_CLR: assert property (meas_valid && !lim_any |-> ##2 !limit_relay)
    else $error("limit clear");
  AST_LIMIT_LAMP: assert property (limit_lamp == limit_relay)
    else $error("limit lamp");
  AST_VOLT_FAULT: assert property (meas_valid && volt_bad |-> ##2 fault_lamp)
    else $error("volt fault");
  AST_INHIBIT: assert property (pulse_inhibit |-> fault_lamp)
    else $error("inhibit");
  AST_POWER_LAMP: assert property (!$past(rst) |-> power_lamp_green != power_lamp_red)
    else $error("power lamp");
  AST_LOCK_LAMP: assert property (!$past(rst, 2) |->
    pulse_lock_lamp == $past(controller_lock_pin, 2))
    else $error("lock lamp");
  AST_OTEMP_LAMP: assert property (!$past(rst, 2) |->
    overtemp_lamp == $past(overtemp_pin, 2))
    else $error("overtemp lamp");
  AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("long wait");
  // main scenarios
  cover property ($rose(limit_relay));
  cover property ($rose(pulse_inhibit));
  cover property ($rose(spare_relay));
endmodule : flm_monitor_checker

bind flm_monitor flm_monitor_checker u_chk (.core_clk(core_clk), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .meas_valid(meas_valid), .line_volt(line_volt), .lim_curr_max(lim_curr_max),
  .lim_volt_max(lim_volt_max), .lim_power_max(lim_power_max),
  .controller_lock_pin(controller_lock_pin), .overtemp_pin(overtemp_pin),
  .limit_relay(limit_relay), .spare_relay(spare_relay),
  .power_lamp_green(power_lamp_green), .power_lamp_red(power_lamp_red),
  .limit_lamp(limit_lamp), .fault_lamp(fault_lamp), .pulse_lock_lamp(pulse_lock_lamp),
  .overtemp_lamp(overtemp_lamp), .pulse_inhibit(pulse_inhibit));

/* File: test/flm_load_model.sv */
/*
  load model: strobes set values every eight cycles, registers pins.
  assumes set values driven on core_clk.
*/
`timescale 1ns/100ps
module flm_load_model (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [15:0]      set_curr,
  input  wire logic [2:0][15:0] set_volt,
  input  wire logic [2:0]       set_lim,
  input  wire logic             set_lock,
  input  wire logic             set_mains,
  input  wire logic             set_otemp,
  output logic                  meas_valid,
  output logic [2:0][15:0]      line_volt,
  output logic [15:0]           load_curr,
  output logic                  lim_curr_max,
  output logic                  lim_volt_max,
  output logic                  lim_power_max,
  output logic                  controller_lock_pin,
  output logic                  mains_ok_pin,
  output logic                  overtemp_pin
);
  logic [2:0] tick;
  // values change with the strobe
  always_ff @(posedge core_clk) begin
    tick       <= rst ? 3'h0 : tick + 3'h1;
    meas_valid <= !rst && (tick == 3'h0);
    if (tick == 3'h0) begin
      line_volt <= set_volt;
      load_curr <= set_curr;
      {lim_power_max, lim_volt_max, lim_curr_max} <= set_lim;
    end
    controller_lock_pin <= set_lock;
    mains_ok_pin        <= set_mains;
    overtemp_pin        <= set_otemp;
  end
endmodule : flm_load_model

/* File: test/tb_top.sv */
/*
  bench for flm_monitor: bus tasks, load model, checked scenarios.
  assumes short reset and drift counts.
*/
`timescale 1ns/100ps
module tb_top;
  import flm_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  logic [15:0] cur = 16'h03e8;
  logic [2:0][15:0] volt = {3{16'h00e6}};
  logic [2:0] lim = 3'h0;
  logic lock = 1'b0, mains = 1'b1, otemp = 1'b0;
  logic mv, lcm, lvm, lpm, lkp, mop, otp;
  logic [2:0][15:0] lv;
  logic [15:0] lc;
  logic alarm, limr, spare, grn, red, liml, fltl, lckl, otl, inh;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  logic [3:0] ra [6] = '{REG_CTRL, REG_ULINE, REG_IABS, REG_IREL, REG_RMASK, 4'h8};
  logic [31:0] rv [6] = '{CTRL_RST, ULINE_RST, IABS_RST, IREL_RST, RMASK_RST, 32'h0};
  logic [15:0] acur [3] = '{16'h0032, 16'h00fa, 16'h0096};
  logic [1:0] aexp [3] = '{2'b01, 2'b10, 2'b00};

  always #20 core_clk = ~core_clk;

  flm_monitor #(.RESET_CYCLES(8), .DRIFT_N(4), .FBUF_DEPTH(8)) u_dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas_valid(mv),
    .line_volt(lv), .load_curr(lc), .lim_curr_max(lcm), .lim_volt_max(lvm),
    .lim_power_max(lpm), .controller_lock_pin(lkp), .mains_ok_pin(mop),
    .overtemp_pin(otp), .alarm_relay(alarm), .limit_relay(limr), .spare_relay(spare),
    .power_lamp_green(grn), .power_lamp_red(red), .limit_lamp(liml), .fault_lamp(fltl),
    .pulse_lock_lamp(lckl), .overtemp_lamp(otl), .pulse_inhibit(inh));

  flm_load_model u_load (.core_clk(core_clk), .rst(rst), .set_curr(cur), .set_volt(volt),
    .set_lim(lim), .set_lock(lock), .set_mains(mains), .set_otemp(otemp),
    .meas_valid(mv), .line_volt(lv), .load_curr(lc), .lim_curr_max(lcm),
    .lim_volt_max(lvm), .lim_power_max(lpm), .controller_lock_pin(lkp),
    .mains_ok_pin(mop), .overtemp_pin(otp));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // one transfer, held through the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= 4'hf;
    avs_write      <= wr;
    avs_read       <= !wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    @(posedge core_clk);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    check(name, rdata, exp);
  endtask : rchk

  // three strobe periods, relay delay included
  task automatic settle();
    repeat (24) @(posedge core_clk);
  endtask : settle

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("lamp_red", {grn, red}, 2'b01);
    repeat (30) @(posedge core_clk);
    check("lamp_green", {grn, red}, 2'b10);
    for (int i = 0; i < 6; i++) rchk(ra[i], rv[i], "reset_value");
    bus(1'b1, 4'h9, 32'hffff_ffff);
    rchk(4'h9, 32'h0, "unmapped");
    bus(1'b1, REG_IREL, 32'h007f_007f);
    rchk(REG_IREL, {9'h0, PCT_OVER_MAX, 9'h0, PCT_UNDER_MAX}, "irel_clamp");
    bus(1'b1, REG_IREL, IREL_RST);
    $display("test registers done");
    // overvoltage, pulse shutdown, closed circuit
    volt[1] <= 16'h012c;
    settle();
    check("fault_open", {fltl, alarm, inh}, 3'b110);
    bus(1'b0, REG_STATUS, 32'h0);
    check("ev_volt", 32'(rdata[0]), 32'h1);
    bus(1'b1, REG_CTRL, 32'h4);
    settle();
    check("inhibit", {fltl, alarm, inh}, 3'b111);
    bus(1'b1, REG_CTRL, 32'h6);
    settle();
    check("closed_fault", {fltl, alarm, inh}, 3'b101);
    volt[1] <= 16'h00e6;
    settle();
    check("closed_ok", {fltl, alarm, inh}, 3'b010);
    rchk(REG_FBUF, 32'h0, "fbuf_hidden");
    bus(1'b1, REG_CTRL, 32'h8);
    bus(1'b0, REG_FBUF, 32'h0);
    check("fbuf_head", 32'({rdata[8], rdata[0]}), 32'h3);
    $display("test faults done");
    for (int i = 0; i < 3; i++) begin
      lim <= 3'h1 << i;
      settle();
      check("limit_on", {limr, liml}, 2'b11);
      lim <= 3'h0;
      settle();
      check("limit_off", {limr, liml}, 2'b00);
    end
    $display("test limits done");
    // lock: spare relay, reference capture
    bus(1'b1, REG_RMASK, 32'h0010_0867);
    bus(1'b1, REG_CTRL, 32'h1);
    lock <= 1'b1;
    settle();
    check("spare_lock", {spare, lckl}, 2'b11);
    lock <= 1'b0;
    settle();
    rchk(REG_REF, 32'h0000_03e8, "ref_capture");
    cur <= 16'h03ea;
    repeat (240) @(posedge core_clk);
    rchk(REG_REF, 32'h0000_03ea, "ref_drift");
    cur <= 16'h0514;
    settle();
    bus(1'b0, REG_STATUS, 32'h0);
    check("rel_over", 32'(rdata[2:1]), 32'h2);
    cur <= 16'h0316;
    settle();
    bus(1'b0, REG_STATUS, 32'h0);
    check("rel_under", 32'(rdata[2:1]), 32'h1);
    $display("test relative done");
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_IABS, 32'h00c8_0064);
    for (int i = 0; i < 3; i++) begin
      cur <= acur[i];
      settle();
      bus(1'b0, REG_STATUS, 32'h0);
      check("abs_limit", 32'(rdata[2:1]), 32'(aexp[i]));
    end
    $display("test absolute done");
    // mains loss: reset again, recapture
    cur <= 16'h0258;
    mains <= 1'b0;
    settle();
    check("mains_loss", {grn, red, alarm}, 3'b011);
    mains <= 1'b1;
    repeat (40) @(posedge core_clk);
    check("mains_back", {grn, red}, 2'b10);
    rchk(REG_REF, 32'h0000_0258, "ref_recapture");
    otemp <= 1'b1;
    settle();
    check("overtemp", {otl, fltl}, 2'b11);
    $display("test mains done");
    finish_test();
  end
endmodule : tb_top
